// *** rtl/tbbr_register.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Ten independent edge-triggered D storage elements share one clock and hold a ten-bit word.
// - In the true variant each element captures its input on the rising edge and shows it unchanged.
// - In the complement variant each element captures on the rising edge and shows the inverse.
// - Output control low drives all ten outputs; output control high floats all ten.
// - Output control only gates the drivers; storage keeps clocking regardless of it.
// - While floating the word is kept or reloaded, and whatever is held is driven on re-enable.
module tbbr_register
    import tbbr_pkg::*;
#(
    parameter tbbr_variant_t VARIANT = TBBR_TRUE_OUT
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [9:0] data_in,
    input  wire logic       output_drive_control_n,
    output var  tbbr_bus_t  bus
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Data and control arrive from pins; two stages before use
    // Bits synchronise one by one: a word that changes near an edge
    // may land split over two cycles, so upstream holds it steady
    logic [9:0] data_meta;
    logic [9:0] data_sync;
    logic       ctrl_meta;
    logic       ctrl_sync;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_meta <= TBBR_STORE_RESET;
            data_sync <= TBBR_STORE_RESET;
        end else begin
            data_meta <= data_in;
            data_sync <= data_meta;
        end
    end

    // Reset floats the bus, matching power-up high impedance
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_meta <= TBBR_FLOAT_RESET;
            ctrl_sync <= TBBR_FLOAT_RESET;
        end else begin
            ctrl_meta <= output_drive_control_n;
            ctrl_sync <= ctrl_meta;
        end
    end

    // ==========================================================
    // Storage
    // ==========================================================
    logic [9:0] store;
    logic [9:0] drive;

    // Control never gates the load path
    // Drive is a twin of store so the inverter sits ahead of the output flop
    genvar i;
    generate
        for (i = 0; i < TBBR_WIDTH; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    store[i] <= TBBR_STORE_RESET[i];
                end else begin
                    store[i] <= data_sync[i];
                end
            end

            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    drive[i] <= TBBR_STORE_RESET[i];
                end else if (VARIANT == TBBR_COMPL_OUT) begin
                    drive[i] <= ~data_sync[i];
                end else begin
                    drive[i] <= data_sync[i];
                end
            end

            bit_capture_a : assert property (@(posedge clk) disable iff (!reset_n)
                $past(reset_n)
                    |-> store[i] == $past(data_sync[i]))
                else $error("storage bit missed its clock edge");
        end
    endgenerate

    // ==========================================================
    // Output drivers
    // ==========================================================
    // Whole struct in one assignment keeps a single driver on the bus
    assign bus = '{
        data_out: drive,
        data_oe:  {TBBR_WIDTH{~ctrl_sync}}
    };

    // ==========================================================
    // Checks
    // ==========================================================
    // Two loads in a row with reset released
    sequence s_load;
        reset_n [*2];
    endsequence

    // Control pin sampled, then both control stages loaded
    sequence s_ctrl_flushed;
        reset_n [*3];
    endsequence

    // Data pin sampled, both stages loaded, then the storage flop
    sequence s_data_flushed;
        reset_n [*4];
    endsequence

    // Bus floating for a cycle, then driven again
    sequence s_reenable;
        ctrl_sync ##1 !ctrl_sync;
    endsequence

    // ==========================================================
    // Reset checks
    // ==========================================================
    // Reset is our own addition; it floats the bus as at power-up
    reset_float_a : assert property (@(posedge clk)
        !reset_n
            |=> bus.data_oe == 10'h000)
        else $error("bus driven after reset");

    reset_clear_a : assert property (@(posedge clk)
        !reset_n
            |=> store == TBBR_STORE_RESET && drive == TBBR_STORE_RESET)
        else $error("word not cleared by reset");

    reset_first_a : assert property (@(posedge clk)
        $rose(reset_n)
            |-> bus.data_oe == 10'h000)
        else $error("bus driven before control stages flushed");

    // ==========================================================
    // Capture checks
    // ==========================================================
    true_capture_a : assert property (@(posedge clk) disable iff (!reset_n)
        (VARIANT == TBBR_TRUE_OUT) && $past(reset_n)
            |-> drive == $past(data_sync))
        else $error("true variant output mismatch");

    compl_capture_a : assert property (@(posedge clk) disable iff (!reset_n)
        (VARIANT == TBBR_COMPL_OUT) && $past(reset_n)
            |-> drive == ~$past(data_sync))
        else $error("complement variant output mismatch");

    variant_map_a : assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n)
            |-> drive == ((VARIANT == TBBR_COMPL_OUT) ? ~store : store))
        else $error("output word does not match stored word");

    // Three edges from pin to store: two stages plus the load
    pin_latency_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_data_flushed
            |-> store == $past(data_in, TBBR_PIN_LATENCY))
        else $error("stored word does not follow the pins");

    sync_stage_a : assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n)
            |-> data_sync == $past(data_meta) && ctrl_sync == $past(ctrl_meta))
        else $error("synchroniser stage skipped");

    width_share_a : assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n)
            |-> (store ^ $past(data_sync)) == 10'h000)
        else $error("bit not captured on shared clock");

    // ==========================================================
    // Output control checks
    // ==========================================================
    enable_drive_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_ctrl_flushed ##0 !$past(output_drive_control_n, TBBR_SYNC_STAGES)
            |-> bus.data_oe == 10'h3ff)
        else $error("outputs not driven while enabled");

    float_bus_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_ctrl_flushed ##0 $past(output_drive_control_n, TBBR_SYNC_STAGES)
            |-> bus.data_oe == 10'h000)
        else $error("outputs driven while disabled");

    reenable_value_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_reenable
            |-> bus.data_oe == 10'h3ff
                && bus.data_out == ((VARIANT == TBBR_COMPL_OUT) ? ~store : store))
        else $error("held word not driven on re-enable");

    // Any differing word must land even while the bus floats
    float_reload_a : assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_sync && $past(reset_n) && $past(data_sync) != $past(store)
            |-> store != $past(store))
        else $error("no load while floating");

    float_hold_a : assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_sync && $past(reset_n) && $stable(data_sync)
            |=> $stable(bus.data_out))
        else $error("floating word changed without a new load");

    // ==========================================================
    // Storage checks
    // ==========================================================
    ctrl_isolated_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_load
            |-> store == $past(data_sync))
        else $error("storage affected by output control");

    float_load_a : assert property (@(posedge clk) disable iff (!reset_n)
        s_load ##0 ctrl_sync
            |-> store == $past(data_sync))
        else $error("storage stalled while floating");

    hold_stable_a : assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $stable(data_sync) ##1 $stable(data_sync)
            |-> $stable(store))
        else $error("stored value drifted between loads");

endmodule
`default_nettype wire

// *** rtl/tbbr_pkg.sv ***
`default_nettype none
package tbbr_pkg;

    // ==========================================================
    // Widths, reset values and latencies
    // ==========================================================
    localparam int         TBBR_WIDTH       = 10;
    localparam logic [9:0] TBBR_STORE_RESET = 10'h000;
    localparam logic       TBBR_FLOAT_RESET = 1'b1;
    localparam int         TBBR_SYNC_STAGES = 2;
    localparam int         TBBR_PIN_LATENCY = 3;

    // Variant selection: true or complemented output
    typedef enum logic {
        TBBR_TRUE_OUT = 1'b0,
        TBBR_COMPL_OUT = 1'b1
    } tbbr_variant_t;

    // Bus-side pin group, two signals per pin
    typedef struct packed {
        logic [9:0] data_out;
        logic [9:0] data_oe;
    } tbbr_bus_t;

endpackage
`default_nettype wire

// *** verif/tbbr_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Upstream source
// ==========
module tbbr_source (
    input  wire logic       clk,
    input  wire logic [9:0] word,
    output var  logic [9:0] data
);
    initial data = 10'h000;
    // Changes just after the edge, as board logic would
    always @(posedge clk) data <= #1 word;
endmodule
`default_nettype wire

// *** verif/tbbr_register_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module tbbr_register_bench;
    import tbbr_pkg::*;
    logic       clk = 1'b0, reset_n = 1'b0, oc_n = 1'b1;
    logic [9:0] word = 10'h000;
    wire  [9:0] din;
    tbbr_bus_t  bt, bc;
    int         error_cnt = 0, compares = 0;
    always #5 clk = ~clk;
    tbbr_source i_src (.clk(clk), .word(word), .data(din));
    tbbr_register #(.VARIANT(TBBR_TRUE_OUT)) i_dut (.clk(clk), .reset_n(reset_n),
        .data_in(din), .output_drive_control_n(oc_n), .bus(bt));
    tbbr_register #(.VARIANT(TBBR_COMPL_OUT)) i_dut_inv (.clk(clk), .reset_n(reset_n),
        .data_in(din), .output_drive_control_n(oc_n), .bus(bc));
    // ==========
    // Helpers
    // ==========
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========
    // Scenarios
    // ==========
    task automatic t_load;
        logic [9:0] w;
        oc_n = 1'b0;
        for (int i = 0; i < 12; i++) begin
            w = (i < 10) ? 10'h001 << i : {10{i[0]}};
            word = w;
            step(6);
            check({bt.data_out, bc.data_out}, {w, ~w});
            check({bt.data_oe, bc.data_oe}, 20'hfffff);
        end
    endtask
    task automatic t_float;
        oc_n = 1'b1;
        step(3);
        check({bt.data_oe, bc.data_oe}, 20'h00000);
        // Load while floating; the new word must show on re-enable
        word = 10'h2a5;
        step(6);
        oc_n = 1'b0;
        step(3);
        check({bt.data_out, bt.data_oe}, {10'h2a5, 10'h3ff});
        check({bc.data_out, bc.data_oe}, {10'h15a, 10'h3ff});
        step(6);
        check({bt.data_out, bc.data_out}, {10'h2a5, 10'h15a});
    endtask
    task automatic t_reset;
        word = 10'h0f0;
        step(6);
        reset_n = 1'b0;
        step(3);
        check({bt.data_oe, bc.data_oe}, 20'h00000);
        reset_n = 1'b1;
        step(1);
        check({bt.data_oe, bc.data_oe}, 20'h00000);
        step(5);
        check({bt.data_out, bc.data_out}, {10'h0f0, 10'h30f});
        check({bt.data_oe, bc.data_oe}, 20'hfffff);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 reset_n = 1'b1;
        check({bt.data_oe, bc.data_oe}, 20'h00000);
        t_load;
        t_float;
        t_reset;
        print_verdict;
    end
    initial begin
        #20000;
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
